// ### core/mfs_map.svh
/*
 * Bit positions, link word numbers and reset values of the module
 * fault status word. Assumes inclusion by bare name from design files.
 */
`ifndef MFS_MAP_SVH
`define MFS_MAP_SVH

// ---------------------------------------------------------------
// Link word numbers
// ---------------------------------------------------------------
`define MFS_LINK_STATUS 4'hb
`define MFS_LINK_SETPOINT_BASE 4'h1
`define MFS_LINK_RELEASE 4'h5

// ---------------------------------------------------------------
// Status word layout
// ---------------------------------------------------------------
`define MFS_BIT_IN_LO 0
`define MFS_BIT_OUT_LO 4
`define MFS_BIT_IN_GRP 8
`define MFS_BIT_OUT_GRP 9
`define MFS_BIT_OUT_CONV 10
`define MFS_BIT_IN_CONV 11
`define MFS_BIT_LINK 12
`define MFS_BIT_SUPERVISOR 13
`define MFS_BIT_SUPPLY 14
`define MFS_BIT_UNUSED_LO 15
`define MFS_STATUS_RESET 32'h0000_0000

// ---------------------------------------------------------------
// Per-channel fields
// ---------------------------------------------------------------
`define MFS_CH_STATUS_W 8
`define MFS_ALARMS_PER_CH 3
`define MFS_RELEASE_STRIDE 4
`define MFS_SETPOINT_RESET 32'h0000_0000
`define MFS_FLT_EXP_HI 30
`define MFS_FLT_EXP_LO 23
`define MFS_FLT_MANT_HI 22

`endif

// ### core/mfs_pkg.sv
/*
 * Types shared by the module fault status word block.
 * Assumes mfs_map.svh supplies the numeric layout.
 */
`include "mfs_map.svh"
package mfs_pkg;
  typedef logic [31:0] mfs_word_t;
  typedef logic [3:0] mfs_link_index_t;

  // Quiet or signalling NaN: all-ones exponent, non-zero mantissa
  function automatic logic mfs_is_nan(input mfs_word_t w);
    mfs_is_nan = (&w[`MFS_FLT_EXP_HI:`MFS_FLT_EXP_LO]) &&
      (|w[`MFS_FLT_MANT_HI:0]);
  endfunction : mfs_is_nan
endpackage : mfs_pkg

// ### core/mfs_sp_if.sv
/*
 * Carrier between the status block and one setpoint holder.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface mfs_sp_if;
  import mfs_pkg::*;
  logic wr_valid;
  mfs_word_t wr_data;
  mfs_word_t value;
  logic nan_flag;
  modport holder (input wr_valid, input wr_data, output value,
                  output nan_flag);
  modport user (output wr_valid, output wr_data, input value,
                input nan_flag);
endinterface : mfs_sp_if

// ### core/mfs_setpoint_hold.sv
/*
 * One output channel setpoint register with invalid-number rejection.
 * Assumes writes arrive as single-cycle strobes on mclk.
 */
`timescale 1ns/10ps
`include "mfs_map.svh"
module mfs_setpoint_hold
  import mfs_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  mfs_sp_if.holder sp
);

  // ---------------------------------------------------------------
  // Hold last valid command
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sp.value <= `MFS_SETPOINT_RESET;
    end else if (sp.wr_valid && !mfs_is_nan(sp.wr_data)) begin
      sp.value <= sp.wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sp.nan_flag <= 1'b0;
    end else if (sp.wr_valid) begin
      sp.nan_flag <= mfs_is_nan(sp.wr_data);
    end
  end

  property p_nan_hold;
    @(posedge mclk) disable iff (!reset_n)
    sp.wr_valid && mfs_is_nan(sp.wr_data) |=>
      sp.nan_flag && $stable(sp.value);
  endproperty
  a_nan_hold: assert property (p_nan_hold)
    else $error("invalid setpoint not held");

endmodule : mfs_setpoint_hold

// ### core/mfs_status_word.sv
/*
 * Module fault status word, output setpoint words and alarm release.
 * Assumes channel status, converter and link flags come from logic on
 * mclk; only the output supply monitor pin is asynchronous.
 */
`timescale 1ns/10ps
`include "mfs_map.svh"
module mfs_status_word
  import mfs_pkg::*;
#(
  parameter int NUM_CH = 4
)(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [31:0] in_chan_status,
  input wire logic [31:0] out_chan_status,
  input wire logic dac_over_temp,
  input wire logic dac_comm_err,
  input wire logic adc_acq_timeout,
  input wire logic adc_comm_err,
  input wire logic link_disrupted,
  input wire logic analog_alive,
  input wire logic supervisor_timeout,
  input wire logic out_supply_fault_pin,
  input wire logic [3:0] alarm_latch_en,
  input wire logic [11:0] out_alarm_raw,
  input wire logic host_wr_valid,
  input wire logic [3:0] host_wr_index,
  input wire logic [31:0] host_wr_data,
  output mfs_word_t data_link_word,
  output logic [3:0][31:0] out_setpoint,
  output logic [3:0] out_nan,
  output logic [11:0] out_alarm_latched,
  output logic in_update_en,
  output logic out_fault_mode,
  output logic out_disable
);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  function automatic logic word_hit(input logic valid,
                                    input mfs_link_index_t idx,
                                    input mfs_link_index_t want);
    word_hit = valid && (idx == want);
  endfunction : word_hit

  // ---------------------------------------------------------------
  // Supply monitor: synchronise and latch
  // ---------------------------------------------------------------
  logic supply_meta;
  logic supply_sync;
  logic supply_latched;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      supply_meta <= 1'b0;
      supply_sync <= 1'b0;
    end else begin
      supply_meta <= out_supply_fault_pin;
      supply_sync <= supply_meta;
    end
  end

  // Only the power-on reset clears this; nothing else may
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      supply_latched <= 1'b0;
    end else if (supply_sync) begin
      supply_latched <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      out_disable <= 1'b0;
    end else begin
      out_disable <= supply_latched || supply_sync;
    end
  end

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0] in_fault;
  logic [NUM_CH-1:0] out_fault;
  mfs_word_t next_status;

  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_fault
      assign in_fault[gc] =
        |in_chan_status[gc*`MFS_CH_STATUS_W +: `MFS_CH_STATUS_W];
      assign out_fault[gc] =
        |out_chan_status[gc*`MFS_CH_STATUS_W +: `MFS_CH_STATUS_W];
    end
  endgenerate

  // Pure function of current sources, so bits drop when sources drop, all but the supply bit, which follows supply_latched
  always_comb begin
    next_status = `MFS_STATUS_RESET;
    next_status[`MFS_BIT_IN_LO +: NUM_CH] = in_fault;
    next_status[`MFS_BIT_OUT_LO +: NUM_CH] = out_fault;
    next_status[`MFS_BIT_IN_GRP] = |in_fault;
    next_status[`MFS_BIT_OUT_GRP] = |out_fault;
    next_status[`MFS_BIT_OUT_CONV] = dac_over_temp || dac_comm_err;
    next_status[`MFS_BIT_IN_CONV] = adc_acq_timeout || adc_comm_err;
    next_status[`MFS_BIT_LINK] = link_disrupted;
    next_status[`MFS_BIT_SUPERVISOR] = supervisor_timeout;
    next_status[`MFS_BIT_SUPPLY] = supply_latched;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      data_link_word <= `MFS_STATUS_RESET;
    end else begin
      data_link_word <= next_status;
    end
  end

  // ---------------------------------------------------------------
  // Link fault consequences
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      in_update_en <= 1'b0;
    end else begin
      in_update_en <= !link_disrupted;
    end
  end

  // A dead analog side cannot drive fault mode anyway
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      out_fault_mode <= 1'b0;
    end else begin
      out_fault_mode <= link_disrupted && analog_alive;
    end
  end

  // ---------------------------------------------------------------
  // Host words: setpoints and alarm release
  // ---------------------------------------------------------------
  mfs_word_t alarm_release_word;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      alarm_release_word <= `MFS_STATUS_RESET;
    end else if (word_hit(host_wr_valid, host_wr_index,
                          `MFS_LINK_RELEASE)) begin
      alarm_release_word <= host_wr_data;
    end
  end

  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_sp
      mfs_sp_if sp ();
      assign sp.wr_valid = word_hit(host_wr_valid, host_wr_index,
        `MFS_LINK_SETPOINT_BASE + 4'(gc));
      assign sp.wr_data = host_wr_data;
      assign out_setpoint[gc] = sp.value;
      assign out_nan[gc] = sp.nan_flag;
      mfs_setpoint_hold u_hold (
        .mclk(mclk),
        .reset_n(reset_n),
        .sp(sp.holder)
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Alarm latching
  // ---------------------------------------------------------------
  genvar gk;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
      for (gk = 0; gk < `MFS_ALARMS_PER_CH; gk++) begin : g_al
        localparam int AI = gc*`MFS_ALARMS_PER_CH + gk;
        localparam int RI = gc*`MFS_RELEASE_STRIDE + gk;
        // New alarm wins over a release in the same cycle
        always_ff @(posedge mclk) begin
          if (!reset_n) begin
            out_alarm_latched[AI] <= 1'b0;
          end else begin
            out_alarm_latched[AI] <= out_alarm_raw[AI] ||
              (out_alarm_latched[AI] && alarm_latch_en[gc] &&
               !alarm_release_word[RI]);
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_in_fault;
    in_chan_status[7:0] != 8'h00 |=> data_link_word[`MFS_BIT_IN_LO];
  endproperty
  a_in_fault: assert property (p_in_fault)
    else $error("input channel fault bit missing");

  property p_out_fault;
    out_chan_status[31:24] != 8'h00 |=> data_link_word[7];
  endproperty
  a_out_fault: assert property (p_out_fault)
    else $error("output channel fault bit missing");

  property p_in_grp;
    data_link_word[`MFS_BIT_IN_GRP] == (|data_link_word[3:0]);
  endproperty
  a_in_grp: assert property (p_in_grp)
    else $error("input group fault mismatch");

  property p_out_grp;
    data_link_word[`MFS_BIT_OUT_GRP] == (|data_link_word[7:4]);
  endproperty
  a_out_grp: assert property (p_out_grp)
    else $error("output group fault mismatch");

  property p_out_conv;
    ##1 data_link_word[`MFS_BIT_OUT_CONV] ==
      $past(dac_over_temp || dac_comm_err);
  endproperty
  a_out_conv: assert property (p_out_conv)
    else $error("output converter fault wrong");

  property p_in_conv;
    ##1 data_link_word[`MFS_BIT_IN_CONV] ==
      $past(adc_acq_timeout || adc_comm_err);
  endproperty
  a_in_conv: assert property (p_in_conv)
    else $error("input converter fault wrong");

  property p_link;
    link_disrupted |=> data_link_word[`MFS_BIT_LINK] && !in_update_en;
  endproperty
  a_link: assert property (p_link)
    else $error("link fault not reported or inputs not frozen");

  property p_fault_mode;
    link_disrupted && analog_alive |=> out_fault_mode;
  endproperty
  a_fault_mode: assert property (p_fault_mode)
    else $error("outputs not in fault mode");

  property p_supervisor;
    supervisor_timeout |=> data_link_word[`MFS_BIT_SUPERVISOR];
  endproperty
  a_supervisor: assert property (p_supervisor)
    else $error("supervisor timeout bit missing");

  sequence s_supply_seen;
    out_supply_fault_pin ##2 supply_sync;
  endsequence
  property p_supply;
    s_supply_seen |=> out_disable ##1 data_link_word[`MFS_BIT_SUPPLY];
  endproperty
  a_supply: assert property (p_supply)
    else $error("supply fault not reported or outputs enabled");

  property p_supply_latch;
    data_link_word[`MFS_BIT_SUPPLY] |=>
      data_link_word[`MFS_BIT_SUPPLY] && out_disable;
  endproperty
  a_supply_latch: assert property (p_supply_latch)
    else $error("supply fault cleared without reset");

  property p_unused;
    data_link_word[31:`MFS_BIT_UNUSED_LO] == 17'h0_0000;
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused status bits not zero");

  property p_alarm_hold;
    out_alarm_latched[0] && alarm_latch_en[0] && !alarm_release_word[0]
      |=> out_alarm_latched[0];
  endproperty
  a_alarm_hold: assert property (p_alarm_hold)
    else $error("latched alarm dropped without release");

  property p_recompute;
    in_chan_status == 32'h0000_0000 && out_chan_status == 32'h0000_0000
      |=> data_link_word[9:0] == 10'h000;
  endproperty
  a_recompute: assert property (p_recompute)
    else $error("summary bits stuck after sources cleared");

endmodule : mfs_status_word

// ### tb/mfs_host_model.sv
/*
 * Host side of the link words: one-cycle write strobes on mclk.
 * Assumes each task is entered just after a falling edge of mclk.
 */
`timescale 1ns/10ps
module mfs_host_model
  import mfs_pkg::*;
(
  input wire logic mclk,
  output logic host_wr_valid,
  output mfs_link_index_t host_wr_index,
  output mfs_word_t host_wr_data
);
  // ------------------------------------------------------------
  // Link word writes
  // ------------------------------------------------------------
  initial begin
    host_wr_valid = 1'b0;
    host_wr_index = 4'h0;
    host_wr_data = 32'h0000_0000;
  end

  // Strobe stays up so back-to-back words need no gap
  task automatic write_word(input mfs_link_index_t idx,
                            input mfs_word_t d);
    host_wr_valid = 1'b1;
    host_wr_index = idx;
    host_wr_data = d;
    @(negedge mclk);
  endtask : write_word

  // Released bus shows inverted data so a stale word never passes
  task automatic idle();
    host_wr_valid = 1'b0;
    host_wr_index = 4'h0;
    host_wr_data = ~host_wr_data;
  endtask : idle

  task automatic release_alarms(input mfs_word_t bits);
    write_word(4'h5, bits);
    write_word(4'h5, 32'h0000_0000);
  endtask : release_alarms
endmodule : mfs_host_model

// ### tb/module_fault_status_word_tb_top.sv
/*
 * Self-checking bench for the module fault status word block.
 * Assumes mfs_host_model drives the link word writes.
 */
`timescale 1ns/10ps
module module_fault_status_word_tb_top
  import mfs_pkg::*;
;
  logic mclk;
  logic reset_n;
  logic [31:0] in_chan_status;
  logic [31:0] out_chan_status;
  logic [5:0] flags;
  logic analog_alive;
  logic out_supply_fault_pin;
  logic [3:0] alarm_latch_en;
  logic [11:0] out_alarm_raw;
  logic host_wr_valid;
  mfs_link_index_t host_wr_index;
  mfs_word_t host_wr_data;
  mfs_word_t data_link_word;
  logic [3:0][31:0] out_setpoint;
  logic [3:0] out_nan;
  logic [11:0] out_alarm_latched;
  logic in_update_en;
  logic out_fault_mode;
  logic out_disable;
  int errors;
  int tests_run;
  int flag_bit [6] = '{10, 10, 11, 11, 12, 13};

  mfs_status_word uut (
    .mclk(mclk), .reset_n(reset_n),
    .in_chan_status(in_chan_status), .out_chan_status(out_chan_status),
    .dac_over_temp(flags[0]), .dac_comm_err(flags[1]),
    .adc_acq_timeout(flags[2]), .adc_comm_err(flags[3]),
    .link_disrupted(flags[4]), .analog_alive(analog_alive),
    .supervisor_timeout(flags[5]),
    .out_supply_fault_pin(out_supply_fault_pin),
    .alarm_latch_en(alarm_latch_en), .out_alarm_raw(out_alarm_raw),
    .host_wr_valid(host_wr_valid), .host_wr_index(host_wr_index),
    .host_wr_data(host_wr_data), .data_link_word(data_link_word),
    .out_setpoint(out_setpoint), .out_nan(out_nan),
    .out_alarm_latched(out_alarm_latched), .in_update_en(in_update_en),
    .out_fault_mode(out_fault_mode), .out_disable(out_disable)
  );

  mfs_host_model host (
    .mclk(mclk), .host_wr_valid(host_wr_valid),
    .host_wr_index(host_wr_index), .host_wr_data(host_wr_data)
  );

  // ------------------------------------------------------------
  // Clock, helpers and closing report
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask : step

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // Whole sequence is about seventy cycles; this only catches a hang
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    $display("Error at %0t: run limit reached", $time);
    finish_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    errors = 0;
    tests_run = 0;
    reset_n = 1'b0;
    in_chan_status = 32'h0000_0000;
    out_chan_status = 32'h0000_0000;
    flags = 6'h00;
    analog_alive = 1'b1;
    out_supply_fault_pin = 1'b0;
    alarm_latch_en = 4'h0;
    out_alarm_raw = 12'h000;
    step(4);
    chk(data_link_word, 32'h0000_0000);
    reset_n = 1'b1;
    step(1);
    chk(data_link_word, 32'h0000_0000);
    chk({29'h0, in_update_en, out_fault_mode, out_disable}, 32'h4);
    // Top and bottom bit of each channel byte
    for (int ch = 0; ch < 4; ch++) begin
      in_chan_status = 32'h0000_0080 << (8 * ch);
      out_chan_status = 32'h0000_0001 << (8 * ch);
      step(1);
      chk(data_link_word, (32'h11 << ch) | 32'h300);
    end
    in_chan_status = 32'h0102_0408;
    out_chan_status = 32'h0000_0000;
    step(1);
    chk(data_link_word, 32'h0000_010f);
    in_chan_status = 32'h0000_0000;
    step(1);
    chk(data_link_word, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      flags = 6'h01 << i;
      step(1);
      chk(data_link_word, 32'h1 << flag_bit[i]);
    end
    flags = 6'h10;
    step(1);
    chk({30'h0, in_update_en, out_fault_mode}, 32'h1);
    analog_alive = 1'b0;
    step(1);
    chk({30'h0, in_update_en, out_fault_mode}, 32'h0);
    flags = 6'h00;
    analog_alive = 1'b1;
    step(1);
    chk({30'h0, in_update_en, out_fault_mode}, 32'h2);
    chk(data_link_word, 32'h0000_0000);
    // Back-to-back setpoints, an ignored index, then a NaN
    host.write_word(4'h1, 32'h3f80_0000);
    host.write_word(4'h2, 32'hc000_0000);
    host.write_word(4'h3, 32'h7f80_0000);
    host.write_word(4'h4, 32'h42c8_0000);
    host.write_word(4'h6, 32'h1234_5678);
    host.write_word(4'h1, 32'h7fc0_0001);
    host.idle();
    chk(out_setpoint[0], 32'h3f80_0000);
    chk({28'h0, out_nan}, 32'h1);
    chk(out_setpoint[1], 32'hc000_0000);
    chk(out_setpoint[2], 32'h7f80_0000);
    chk(out_setpoint[3], 32'h42c8_0000);
    step(1);
    host.write_word(4'h1, 32'hbf80_0000);
    host.idle();
    chk(out_setpoint[0], 32'hbf80_0000);
    chk({28'h0, out_nan}, 32'h0);
    // Channel 2 over-range latched, channel 0 under-range follows raw
    alarm_latch_en = 4'h4;
    out_alarm_raw = 12'h081;
    step(1);
    chk({20'h0, out_alarm_latched}, 32'h081);
    out_alarm_raw = 12'h000;
    step(3);
    chk({20'h0, out_alarm_latched}, 32'h080);
    host.release_alarms(32'h0000_0200);
    host.idle();
    chk({20'h0, out_alarm_latched}, 32'h000);
    // All channels latched; a raw alarm outlasts its own release
    alarm_latch_en = 4'hf;
    out_alarm_raw = 12'hfff;
    step(1);
    out_alarm_raw = 12'h004;
    step(2);
    chk({20'h0, out_alarm_latched}, 32'hfff);
    host.release_alarms(32'h0000_7777);
    host.idle();
    chk({20'h0, out_alarm_latched}, 32'h004);
    out_alarm_raw = 12'h000;
    step(1);
    chk({20'h0, out_alarm_latched}, 32'h004);
    alarm_latch_en = 4'h0;
    step(1);
    chk({20'h0, out_alarm_latched}, 32'h000);
    // Supply fault pulse; only reset may clear it
    out_supply_fault_pin = 1'b1;
    step(1);
    out_supply_fault_pin = 1'b0;
    step(3);
    chk(data_link_word, 32'h0000_4000);
    chk({31'h0, out_disable}, 32'h1);
    host.release_alarms(32'hffff_ffff);
    host.idle();
    step(20);
    chk(data_link_word, 32'h0000_4000);
    chk({31'h0, out_disable}, 32'h1);
    reset_n = 1'b0;
    step(2);
    reset_n = 1'b1;
    step(1);
    chk(data_link_word, 32'h0000_0000);
    chk({31'h0, out_disable}, 32'h0);
    chk(out_setpoint[0], 32'h0000_0000);
    finish_test();
  end
endmodule : module_fault_status_word_tb_top
